/* hw/acs_pkg.sv */
// Functional notes
// - In 14-bit use, upper result register shows result bits 13:6.
// - In 8-bit use, upper register shows bits 7:0; lower register meaningless.
// - Lower register holds result bits 5:0; bits 7 and 6 read zero.
// - Enable set and single-pass clear converts continuously; enable clear stops.
// - Sweep bit picks one named channel (0) or all channels (1).
// - Code 00 converts the named channel repeatedly forever.
// - Code 01 converts channels 0 to 7 in order, looping forever.
// - Code 10 converts the named channel exactly once, then stops.
// - Code 11 converts channels 0 to 7 once each, then halts.
// - Bit 4 disables the input buffer when set; software keeps it zero.
// - Bit 3 swaps the two buffer amplifier inputs when set.
// - Bits 2:0 report a fixed silicon revision; writes do not change it.
// - Conversion channel field selects which analogue input is converted.
// - Readback channel field picks which stored result is shown.
// - Done flag in bit 7 of second config reads 1 after a conversion.
`default_nettype none
package acs_pkg;

    localparam logic [7:0] ADDR_RES_UPPER = 8'h07;
    localparam logic [7:0] ADDR_RES_LOWER = 8'h08;
    localparam logic [7:0] ADDR_MODE_CFG  = 8'h09;
    localparam logic [7:0] ADDR_CHAN_CFG  = 8'h0a;

    localparam int MODE_EN_BIT     = 7;
    localparam int MODE_ONCE_BIT   = 6;
    localparam int MODE_SWEEP_BIT  = 5;
    localparam int MODE_BUFDIS_BIT = 4;
    localparam int MODE_SWAP_BIT   = 3;
    localparam int CHAN_READY_BIT  = 7;
    localparam int CHAN_RDBK_LSB   = 3;
    localparam int CHAN_CONV_LSB   = 0;

    localparam logic [4:0] MODE_CFG_RST = 5'h00;
    localparam logic [2:0] CHAN_SEL_RST = 3'h0;

    localparam int NUM_CHANNELS = 8;
    localparam int CHAN_W       = 3;
    localparam int RESULT_W     = 14;

    typedef enum logic [2:0] {
        ACS_CH_ILIM  = 3'h0,
        ACS_CH_VIN   = 3'h1,
        ACS_CH_VBAT  = 3'h2,
        ACS_CH_OLIM  = 3'h3,
        ACS_CH_THERM = 3'h4,
        ACS_CH_DIE_T = 3'h5,
        ACS_CH_EXT   = 3'h6,
        ACS_CH_AGND  = 3'h7
    } acs_channel_e;

    function automatic logic [7:0] acs_upper(input logic [RESULT_W-1:0] r,
                                             input logic wide);
        return wide ? r[13:6] : r[7:0];
    endfunction : acs_upper

    function automatic logic [7:0] acs_lower(input logic [RESULT_W-1:0] r,
                                             input logic wide);
        return wide ? {2'b00, r[5:0]} : 8'h00;
    endfunction : acs_lower

endpackage : acs_pkg
`default_nettype wire

/* hw/acs_mem_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface acs_mem_if #(
    parameter int W  = 14,
    parameter int AW = 3
);
    logic          we;
    logic [AW-1:0] waddr;
    logic [W-1:0]  wdata;
    logic [AW-1:0] raddr;
    logic [W-1:0]  rdata;

    modport writer (output we, waddr, wdata, raddr, input rdata);
    modport store  (input we, waddr, wdata, raddr, output rdata);
endinterface : acs_mem_if
`default_nettype wire

/* hw/acs_result_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module acs_result_mem #(
    parameter int W     = 14,
    parameter int DEPTH = 8
) (
    input  wire logic  clk_i,
    input  wire logic  sys_rst_i,
    acs_mem_if.store   port
);
    import acs_pkg::*;

    if (W < 1 || DEPTH != (1 << CHAN_W))
        $error("DEPTH must cover every channel code exactly");

    logic [W-1:0]     mem [DEPTH];
    logic [DEPTH-1:0] valid_q;
    logic [W-1:0]     rdata_q;

    // ------------------------------------------------------------
    // Storage; unwritten entries read as zero.
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (port.we)
            mem[port.waddr] <= port.wdata;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            valid_q <= '0;
        else if (port.we)
            valid_q[port.waddr] <= 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            rdata_q <= '0;
        else
            rdata_q <= valid_q[port.raddr] ? mem[port.raddr] : '0;
    end

    assign port.rdata = rdata_q;
endmodule : acs_result_mem
`default_nettype wire

/* hw/acs_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer (
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic                 enable_i,
    input  wire logic                 once_i,
    input  wire logic                 sweep_i,
    input  wire logic [2:0]           chan_sel_i,
    input  wire logic                 rearm_i,
    input  wire logic                 done_i,
    output logic                      start_o,
    output acs_pkg::acs_channel_e     chan_o,
    output logic                      busy_o
);
    import acs_pkg::*;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONVERT, SEQ_HALT} acs_seq_e;

    acs_seq_e     state_q;
    acs_seq_e     state_d;
    logic [2:0]   chan_q;
    logic [2:0]   chan_d;
    logic         start_q;
    logic         start_d;

    wire [2:0] first_chan = sweep_i ? 3'h0 : chan_sel_i;
    wire       last_chan  = !sweep_i || (chan_q == 3'h7);

    // ------------------------------------------------------------
    // Conversion sequencing.
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        chan_d  = chan_q;
        start_d = 1'b0;
        case (state_q)
            SEQ_IDLE:
            begin
                if (enable_i)
                begin
                    chan_d  = first_chan;
                    start_d = 1'b1;
                    state_d = SEQ_CONVERT;
                end
            end
            SEQ_CONVERT:
            begin
                if (!enable_i)
                    state_d = SEQ_IDLE;
                else if (done_i)
                begin
                    if (!last_chan)
                    begin
                        chan_d  = chan_q + 3'h1;
                        start_d = 1'b1;
                    end
                    else if (once_i)
                        state_d = SEQ_HALT;
                    else
                    begin
                        chan_d  = first_chan;
                        start_d = 1'b1;
                    end
                end
            end
            SEQ_HALT:
            begin
                if (!enable_i || rearm_i)
                    state_d = SEQ_IDLE;
            end
            default:
                state_d = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state_q <= SEQ_IDLE;
            chan_q  <= CHAN_SEL_RST;
            start_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            chan_q  <= chan_d;
            start_q <= start_d;
        end
    end

    assign start_o = start_q;
    assign chan_o  = acs_channel_e'(chan_q);
    assign busy_o  = (state_q == SEQ_CONVERT);
endmodule : acs_sequencer
`default_nettype wire

/* hw/acs_top.sv */
`timescale 1ns/100ps
`default_nettype none
module acs_top #(
    parameter int         RESULT_BITS  = 14,
    parameter logic [2:0] SILICON_REV  = 3'h0 // Value is arbitrary.
) (
    input  wire logic                          clk_i,
    input  wire logic                          sys_rst_i,
    input  wire logic [7:0]                    reg_addr_i,
    input  wire logic                          reg_wr_i,
    input  wire logic [7:0]                    reg_wdata_i,
    input  wire logic                          reg_rd_i,
    output logic [7:0]                         reg_rdata_o,
    input  wire logic                          conv_done_i,
    input  wire logic [acs_pkg::RESULT_W-1:0]  conv_data_i,
    output logic                               adc_enable_o,
    output logic                               conv_start_o,
    output acs_pkg::acs_channel_e              conv_channel_o,
    output logic                               input_buffer_disable_o,
    output logic                               input_swap_o,
    output logic                               conv_busy_o
);
    import acs_pkg::*;

    if (RESULT_BITS != 8 && RESULT_BITS != 14)
        $error("RESULT_BITS must be 8 or 14");

    localparam logic WIDE = (RESULT_BITS == 14);

    logic [4:0]           mode_q;
    logic [2:0]           readback_channel_field_q;
    logic [2:0]           conversion_channel_field_q;
    logic                 ready_q;
    logic [7:0]           rdata_q;
    logic                 done_s1_q;
    logic                 done_s2_q;
    logic                 done_s3_q;
    logic [RESULT_W-1:0]  data_s1_q;
    logic [RESULT_W-1:0]  data_s2_q;
    logic                 seq_start;
    acs_channel_e         seq_chan;
    logic                 seq_busy;

    acs_mem_if #(.W(RESULT_W), .AW(CHAN_W)) mem_bus ();

    // ------------------------------------------------------------
    // Register decode.
    // ------------------------------------------------------------
    wire wr_mode  = reg_wr_i && (reg_addr_i == ADDR_MODE_CFG);
    wire wr_chan  = reg_wr_i && (reg_addr_i == ADDR_CHAN_CFG);
    wire rd_upper = reg_rd_i && (reg_addr_i == ADDR_RES_UPPER);

    wire adc_enable           = mode_q[MODE_EN_BIT - 3];
    wire adc_once             = mode_q[MODE_ONCE_BIT - 3];
    wire all_channel_sweep    = mode_q[MODE_SWEEP_BIT - 3];
    wire input_buffer_disable = mode_q[MODE_BUFDIS_BIT - 3];
    wire input_swap           = mode_q[MODE_SWAP_BIT - 3];

    wire done_pulse = done_s2_q && !done_s3_q;

    wire [7:0] mode_rd = {mode_q, SILICON_REV};
    wire [7:0] chan_rd = {ready_q, 1'b0, readback_channel_field_q,
                          conversion_channel_field_q};
    wire [7:0] upper_rd = acs_upper(mem_bus.rdata, WIDE);
    wire [7:0] lower_rd = acs_lower(mem_bus.rdata, WIDE);

    wire [7:0] rd_mux =
        (reg_addr_i == ADDR_RES_UPPER) ? upper_rd :
        (reg_addr_i == ADDR_RES_LOWER) ? lower_rd :
        (reg_addr_i == ADDR_MODE_CFG)  ? mode_rd  :
        (reg_addr_i == ADDR_CHAN_CFG)  ? chan_rd  : 8'h00;

    // ------------------------------------------------------------
    // Configuration registers.
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            mode_q <= MODE_CFG_RST;
        else if (wr_mode)
            mode_q <= reg_wdata_i[7:3];
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            readback_channel_field_q   <= CHAN_SEL_RST;
            conversion_channel_field_q <= CHAN_SEL_RST;
        end
        else if (wr_chan)
        begin
            readback_channel_field_q   <= reg_wdata_i[CHAN_RDBK_LSB +: 3];
            conversion_channel_field_q <= reg_wdata_i[CHAN_CONV_LSB +: 3];
        end
    end

    // Done flag: set on each finished conversion, cleared by reading the
    // upper result register; a set in the same cycle wins.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            ready_q <= 1'b0;
        else if (done_pulse)
            ready_q <= 1'b1;
        else if (rd_upper)
            ready_q <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            rdata_q <= 8'h00;
        else if (reg_rd_i)
            rdata_q <= rd_mux;
    end

    // ------------------------------------------------------------
    // Converter input synchronisers.
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            done_s3_q <= 1'b0;
            data_s1_q <= '0;
            data_s2_q <= '0;
        end
        else
        begin
            done_s1_q <= conv_done_i;
            done_s2_q <= done_s1_q;
            done_s3_q <= done_s2_q;
            data_s1_q <= conv_data_i;
            data_s2_q <= data_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Sequencer and result store.
    // ------------------------------------------------------------
    acs_sequencer u_seq (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .enable_i   (adc_enable),
        .once_i     (adc_once),
        .sweep_i    (all_channel_sweep),
        .chan_sel_i (conversion_channel_field_q),
        .rearm_i    (wr_mode),
        .done_i     (done_pulse && seq_busy),
        .start_o    (seq_start),
        .chan_o     (seq_chan),
        .busy_o     (seq_busy)
    );

    assign mem_bus.we    = done_pulse && seq_busy;
    assign mem_bus.waddr = seq_chan;
    assign mem_bus.wdata = data_s2_q;
    assign mem_bus.raddr = readback_channel_field_q;

    acs_result_mem #(.W(RESULT_W), .DEPTH(NUM_CHANNELS)) u_mem (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .port      (mem_bus)
    );

    assign reg_rdata_o            = rdata_q;
    assign adc_enable_o           = adc_enable;
    assign conv_start_o           = seq_start;
    assign conv_channel_o         = seq_chan;
    assign input_buffer_disable_o = input_buffer_disable;
    assign input_swap_o           = input_swap;
    assign conv_busy_o            = seq_busy;
endmodule : acs_top
`default_nettype wire

/* bench/acs_top_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module acs_top_chk
#(
    parameter int         RESULT_BITS = 14,
    parameter logic [2:0] SILICON_REV = 3'h0
) (
    input wire logic                         clk_i,
    input wire logic                         sys_rst_i,
    input wire logic [7:0]                   reg_addr_i,
    input wire logic                         reg_wr_i,
    input wire logic [7:0]                   reg_wdata_i,
    input wire logic                         reg_rd_i,
    input wire logic [7:0]                   reg_rdata_o,
    input wire logic                         conv_done_i,
    input wire logic [acs_pkg::RESULT_W-1:0] conv_data_i,
    input wire logic                         adc_enable_o,
    input wire logic                         conv_start_o,
    input wire acs_pkg::acs_channel_e        conv_channel_o,
    input wire logic                         input_buffer_disable_o,
    input wire logic                         input_swap_o,
    input wire logic                         conv_busy_o
);
    import acs_pkg::*;
    // ----
    // Tracks the mode and field that software wrote.
    // ----
    logic [1:0] mode_q;
    logic [2:0] fld_q;
    logic [2:0] last_q;
    logic       seen_q;
    logic [3:0] cnt_q;
    logic       wr9_q;
    logic       wra_q;
    logic [7:0] wdat_q;
    wire        wr9 = reg_wr_i && reg_addr_i == ADDR_MODE_CFG;
    wire        wra = reg_wr_i && reg_addr_i == ADDR_CHAN_CFG;
    // The sequencer acts on a write one edge after it lands, so these lag.
    always_ff @(posedge clk_i)
    begin
        wr9_q  <= !sys_rst_i && wr9;
        wra_q  <= !sys_rst_i && wra;
        wdat_q <= reg_wdata_i;
    end
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || wr9_q)
        begin
            seen_q <= 1'b0;
            cnt_q  <= 4'h0;
        end
        else if (conv_start_o)
        begin
            seen_q <= 1'b1;
            cnt_q  <= cnt_q + 4'h1;
        end
    end
    always_ff @(posedge clk_i)
    begin
        mode_q <= sys_rst_i ? 2'b00 : (wr9_q ? wdat_q[6:5] : mode_q);
        fld_q  <= sys_rst_i ? 3'h0 : (wra_q ? wdat_q[2:0] : fld_q);
        last_q <= conv_start_o ? conv_channel_o : last_q;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    AST_START_PULSE: assert property (conv_start_o |=> !conv_start_o)
        else $error("start pulse too long");
    AST_START_EN: assert property ($rose(adc_enable_o) |=> conv_start_o
        && conv_busy_o) else $error("no start after enable");
    AST_NO_START_OFF: assert property (!adc_enable_o
        && !$past(adc_enable_o) |-> !conv_start_o) else $error("start off");
    AST_SINGLE_CH: assert property (conv_start_o && !mode_q[0]
        |-> conv_channel_o == fld_q) else $error("wrong single channel");
    AST_SWEEP_FIRST: assert property (conv_start_o && mode_q[0]
        && !seen_q |-> conv_channel_o == ACS_CH_ILIM) else $error("sweep 0");
    AST_SWEEP_NEXT: assert property (conv_start_o && mode_q[0] && seen_q
        |-> conv_channel_o == last_q + 3'h1) else $error("sweep order");
    AST_ONCE_STOP: assert property (conv_start_o && mode_q[1]
        |-> cnt_q < (mode_q[0] ? 4'h8 : 4'h1)) else $error("extra start");
    AST_MODE_BITS: assert property ($past(wr9) |-> {adc_enable_o,
        input_buffer_disable_o, input_swap_o} == {$past(reg_wdata_i[7]),
        $past(reg_wdata_i[4:3])}) else $error("mode bits");
    AST_READ_REV: assert property ($past(reg_rd_i && reg_addr_i ==
        ADDR_MODE_CFG) |-> reg_rdata_o[2:0] == SILICON_REV)
        else $error("revision field");
    AST_LOWER_RSV: assert property ($past(reg_rd_i && reg_addr_i ==
        ADDR_RES_LOWER) |-> reg_rdata_o[7:6] == 2'b00)
        else $error("lower reserved bits");
endmodule : acs_top_chk
`default_nettype wire

/* bench/acs_conv_model.sv */
`timescale 1ns/100ps
`default_nettype none
module acs_conv_model (
    input  wire logic        clk_i,
    input  wire logic        start_i,
    input  wire logic [2:0]  chan_i,
    output logic             done_o,
    output logic [13:0]      data_o
);
    // ----
    // Converter with a latency that grows with the channel number.
    // A start is looked at on every edge while idle, the one ending a conversion too.
    // ----
    logic [2:0] ch;
    initial
    begin
        ch     = 3'h0;
        done_o = 1'b0;
        data_o = 14'h0000;
        @(posedge clk_i);
        forever
        begin
            if (start_i === 1'b1)
            begin
                ch = chan_i;
                repeat (2 + 3 * ch) @(posedge clk_i);
                data_o <= {ch, 3'h5, ch, 5'h13};
                repeat (3) @(posedge clk_i);
                done_o <= 1'b1;
                repeat (2) @(posedge clk_i);
                done_o <= 1'b0;
                repeat (2) @(posedge clk_i);
                data_o <= ~data_o;
            end
            else
                @(posedge clk_i);
        end
    end
endmodule : acs_conv_model
`default_nettype wire

/* bench/acs_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module acs_top_tb;
    import acs_pkg::*;
    // ----
    // Register accesses and conversion scenarios.
    // ----
    logic         clk_i, sys_rst_i, wr, rd, done, en, start, bdis, swap, busy;
    logic [7:0]   addr, wdata, d, rdata;
    logic [13:0]  cdata, r;
    acs_channel_e chan;
    int           fail_count, compares, cycles, starts, n;
    acs_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .conv_done_i(done), .conv_data_i(cdata),
        .adc_enable_o(en), .conv_start_o(start), .conv_channel_o(chan),
        .input_buffer_disable_o(bdis), .input_swap_o(swap),
        .conv_busy_o(busy));
    acs_conv_model model (.clk_i(clk_i), .start_i(start), .chan_i(chan),
        .done_o(done), .data_o(cdata));
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic give_verdict;
        if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    always @(posedge clk_i)
    begin
        cycles++;
        if (start === 1'b1) starts++;
        if (cycles == 20000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    function automatic logic [13:0] rv(input logic [2:0] c);
        return {c, 3'h5, c, 5'h13};
    endfunction : rv
    initial
    begin
        sys_rst_i = 1'b1;
        {wr, rd, addr, wdata} = '0;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int a = 7; a < 12; a++)
        begin
            rd_reg(a[7:0]);
            chk(d, 8'h00);
        end
        wr_reg(ADDR_MODE_CFG, 8'h1f);
        rd_reg(ADDR_MODE_CFG);
        chk(d, 8'h18);
        chk({6'h0, bdis, swap}, 8'h03);
        wr_reg(ADDR_MODE_CFG, 8'h00);
        starts = 0;
        for (int c = 0; c < 8; c++)
        begin
            wr_reg(ADDR_CHAN_CFG, {2'b00, c[2:0], c[2:0]});
            wr_reg(ADDR_MODE_CFG, c[0] ? 8'hc8 : 8'hc0);
            d = 8'h00;
            for (int i = 0; i < 100 && d[7] !== 1'b1; i++)
                rd_reg(ADDR_CHAN_CFG);
            chk({7'h0, d[7]}, 8'h01);
            chk({7'h0, swap}, {7'h0, c[0]});
            repeat (2) @(posedge clk_i);
            r = rv(c[2:0]);
            rd_reg(ADDR_RES_UPPER);
            chk(d, r[13:6]);
            rd_reg(ADDR_RES_LOWER);
            chk(d, {2'b00, r[5:0]});
            rd_reg(ADDR_CHAN_CFG);
            chk(d, {2'b00, c[2:0], c[2:0]});
        end
        chk(starts[7:0], 8'h08);
        starts = 0;
        wr_reg(ADDR_MODE_CFG, 8'he0);
        for (int i = 0; i < 600 && starts < 8; i++) @(posedge clk_i);
        repeat (80) @(posedge clk_i);
        chk(starts[7:0], 8'h08);
        wr_reg(ADDR_CHAN_CFG, 8'h28);
        repeat (2) @(posedge clk_i);
        r = rv(3'h5);
        rd_reg(ADDR_RES_UPPER);
        chk(d, r[13:6]);
        for (int m = 0; m < 2; m++)
        begin
            #1 starts = 0;
            wr_reg(ADDR_MODE_CFG, m ? 8'ha0 : 8'h80);
            repeat (400) @(posedge clk_i);
            wr_reg(ADDR_MODE_CFG, 8'h00);
            #1 n = starts;
            repeat (100) @(posedge clk_i);
            chk({7'h0, n > 9}, 8'h01);
            chk({7'h0, starts <= n + 1}, 8'h01);
            chk({7'h0, busy}, 8'h00);
        end
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd_reg(ADDR_RES_UPPER);
        chk(d, 8'h00);
        give_verdict();
    end
endmodule : acs_top_tb
bind acs_top acs_top_chk #(.RESULT_BITS(RESULT_BITS),
    .SILICON_REV(SILICON_REV)) chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
    .adc_enable_o(adc_enable_o), .conv_start_o(conv_start_o),
    .conv_channel_o(conv_channel_o),
    .input_buffer_disable_o(input_buffer_disable_o),
    .input_swap_o(input_swap_o), .conv_busy_o(conv_busy_o));
`default_nettype wire
